//--- hdl/flash_status_pkg.sv
package flash_status_pkg;
    // Clock and internal register-write time
    localparam int CLK_PERIOD_NS = 25;
    localparam int WREG_TIME_NS = 1000;
    localparam int WREG_CYCLES = (WREG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command opcodes
    localparam logic [7:0] OPC_WRITE_REGS = 8'h01;
    localparam logic [7:0] OPC_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_READ_STATUS2 = 8'h07;
    localparam logic [7:0] OPC_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] OPC_ERASE_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_PROGRAM_SUSPEND = 8'h85;
    localparam logic [7:0] OPC_WHOLE_ERASE = 8'hc7;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] OPC_SOFT_RESET = 8'hf0;

    // Frame lengths in bits at which fields are complete, and the bit counter's limit
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_WRR = 6'h10;
    localparam logic [5:0] BITS_ADDR = 6'h20;
    localparam logic [5:0] BITS_PROG = 6'h28;
    localparam logic [5:0] BITS_MAX = 6'h3f;

    // Status register field positions and defaults
    localparam int LOCK_POS = 7;
    localparam int PERR_POS = 6;
    localparam int EERR_POS = 5;
    localparam int BP_HI_POS = 4;
    localparam int BP_LO_POS = 2;
    localparam int WEL_POS = 1;
    localparam int BUSY_POS = 0;
    localparam logic [2:0] BP_VOLATILE_DEFAULT = 3'h7;
    localparam logic [2:0] BP_RESET = 3'h0;
    localparam logic [7:0] STATUS2_VALUE = 8'h00;
    localparam int ADDR_W = 24;

    typedef enum logic [1:0] {
        OP_PROGRAM = 2'h0,
        OP_ERASE = 2'h1,
        OP_WHOLE = 2'h2
    } array_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REG = 2'b01,
        ST_ARRAY = 2'b11,
        ST_ERROR = 2'b10
    } op_state_t;

    typedef struct packed {
        logic start;
        array_op_t op;
        logic [ADDR_W-1:0] addr;
        logic suspend;
        logic abort;
    } array_req_t;

    typedef struct packed {
        logic done;
        logic fail;
    } array_rsp_t;
endpackage : flash_status_pkg

//--- hdl/pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("pin_sync WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : pin_sync

//--- hdl/flash_status_ctrl.sv
// Overview of operation
// - Lock bit plus low protect pin blocks writes
// - Otherwise register write changes lock and levels
// - Program failure or protected target sets error
// - Erase failure or protected sector sets error
// - Clear-status command clears both error flags
// - Error flags read-only, untouched by writes
// - Whole erase only at zero levels, no error
// - Levels volatile default ones when configured
// - Refuse program/erase inside protected area
// - Writes need write-enable latch set
// - Only the enable command sets the latch
// - Successful operation end clears the latch
// - Latch zero after any reset
// - Busy bit high during every operation
// - While busy accept only listed commands
// - Suspend only during matching array operation
// - Error flag keeps busy until clear-status
// - Status read returns register, even while busy
// - Register write loads lock and level bits
// - Volatile bits take defaults after resets
module flash_status_ctrl #(
    parameter int WREG_CYCLES = flash_status_pkg::WREG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic write_protect_n_in,
    input wire logic protect_volatility_bit_in,
    input wire logic target_protected_in,
    input wire flash_status_pkg::array_rsp_t array_rsp_in,
    output flash_status_pkg::array_req_t array_req_out,
    output logic [2:0] protect_level_out,
    output logic [7:0] device_status_control_out,
    output logic miso_out,
    output logic miso_oe_out
);
    localparam int CW = $clog2(WREG_CYCLES + 1);
    localparam int WREG_TAIL = WREG_CYCLES - 1;

    // The register-write timing check needs at least two busy cycles
    if (WREG_CYCLES < 2) begin : g_chk
        $error("WREG_CYCLES must be at least 2");
    end

    logic [3:0] pins_s;
    logic sck_s;
    logic cs_n_s;
    logic mosi_s;
    logic wp_n_s;
    logic sck_prev_q;
    logic cs_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [5:0] nbits_q;
    logic [7:0] shift_in_q;
    logic [7:0] opcode_q;
    logic [7:0] wrr_byte_q;
    logic [flash_status_pkg::ADDR_W-1:0] addr_q;
    logic [7:0] next_byte;
    logic rd_mode_q;
    logic [2:0] out_cnt_q;
    logic [7:0] out_sh_q;
    logic miso_q;
    flash_status_pkg::op_state_t state_q;
    flash_status_pkg::array_op_t op_q;
    logic [CW-1:0] wreg_cnt_q;
    logic busy;
    logic lock_q;
    logic [2:0] bp_q;
    logic perr_q;
    logic eerr_q;
    logic wel_q;
    logic init_q;
    logic hw_lock;
    logic frame8;
    logic cmd_write_enable_cmd;
    logic cmd_write_disable_cmd;
    logic cmd_clear_status_cmd;
    logic cmd_rst;
    logic cmd_wrr;
    logic cmd_prog;
    logic cmd_erase;
    logic cmd_whole;
    logic cmd_esus;
    logic cmd_psus;
    logic array_end;
    logic array_ok;
    logic reg_end;
    logic perr_set;
    logic eerr_set;
    flash_status_pkg::array_req_t req_q;

    // Serial pins are asynchronous to the core clock
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in({sck_in, ~cs_n_in, mosi_in, ~write_protect_n_in}),
        .q_out(pins_s)
    );

    // Select and protect travel inverted so the synchroniser's reset value
    // matches their idle high level and no false select edge follows reset
    assign {sck_s, cs_n_s, mosi_s, wp_n_s} = pins_s ^ 4'h5;

    // Edge detection on synchronised serial clock and select
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
    assign cs_rise = cs_n_s & ~cs_prev_q;

    // Input shifting; fields latched as their last bit arrives
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            nbits_q <= 6'h00;
            shift_in_q <= 8'h00;
            opcode_q <= 8'h00;
            wrr_byte_q <= 8'h00;
            addr_q <= '0;
        end else if (cs_n_s) begin
            nbits_q <= 6'h00;
        end else if (sck_rise) begin
            shift_in_q <= {shift_in_q[6:0], mosi_s};
            if (nbits_q != flash_status_pkg::BITS_MAX) begin
                nbits_q <= nbits_q + 6'h01;
            end
            if (nbits_q == flash_status_pkg::BITS_OPCODE - 6'h01) begin
                opcode_q <= {shift_in_q[6:0], mosi_s};
            end
            if (nbits_q == flash_status_pkg::BITS_WRR - 6'h01) begin
                wrr_byte_q <= {shift_in_q[6:0], mosi_s};
            end
            if (nbits_q >= flash_status_pkg::BITS_OPCODE &&
                nbits_q < flash_status_pkg::BITS_ADDR) begin
                addr_q <= {addr_q[flash_status_pkg::ADDR_W-2:0], mosi_s};
            end
        end
    end

    // Status register image
    assign busy = (state_q != flash_status_pkg::ST_IDLE);
    assign device_status_control_out = {lock_q, perr_q, eerr_q, bp_q, wel_q, busy};
    assign protect_level_out = bp_q;

    assign next_byte = (opcode_q == flash_status_pkg::OPC_READ_STATUS2) ?
        flash_status_pkg::STATUS2_VALUE : device_status_control_out;

    // Read mode begins once a status-read opcode is complete
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_mode_q <= 1'b0;
        end else if (cs_n_s) begin
            rd_mode_q <= 1'b0;
        end else if (sck_rise && nbits_q == flash_status_pkg::BITS_OPCODE - 6'h01) begin
            rd_mode_q <= ({shift_in_q[6:0], mosi_s} == flash_status_pkg::OPC_READ_STATUS) ||
                ({shift_in_q[6:0], mosi_s} == flash_status_pkg::OPC_READ_STATUS2);
        end
    end

    // Output shifter reloads a fresh byte every eight falling edges
    // so a host polling busy sees each new snapshot
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_cnt_q <= 3'h0;
            out_sh_q <= 8'h00;
            miso_q <= 1'b0;
        end else if (!rd_mode_q) begin
            out_cnt_q <= 3'h0;
        end else if (sck_fall) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == 3'h0) begin
                miso_q <= next_byte[7];
                out_sh_q <= {next_byte[6:0], 1'b0};
            end else begin
                miso_q <= out_sh_q[7];
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    assign miso_out = miso_q;
    assign miso_oe_out = rd_mode_q;

    // Command acceptance, evaluated as chip select rises
    assign hw_lock = lock_q & ~wp_n_s;
    assign frame8 = cs_rise && nbits_q == flash_status_pkg::BITS_OPCODE;
    assign cmd_write_enable_cmd = frame8 && !busy &&
        opcode_q == flash_status_pkg::OPC_WRITE_ENABLE;
    assign cmd_write_disable_cmd = frame8 && !busy &&
        opcode_q == flash_status_pkg::OPC_WRITE_DISABLE;
    assign cmd_clear_status_cmd = frame8 && opcode_q == flash_status_pkg::OPC_CLEAR_STATUS;
    assign cmd_rst = frame8 && opcode_q == flash_status_pkg::OPC_SOFT_RESET;
    assign cmd_wrr = cs_rise && !busy && wel_q && !hw_lock &&
        nbits_q >= flash_status_pkg::BITS_WRR &&
        opcode_q == flash_status_pkg::OPC_WRITE_REGS;
    assign cmd_prog = cs_rise && !busy && wel_q &&
        nbits_q >= flash_status_pkg::BITS_PROG &&
        opcode_q == flash_status_pkg::OPC_PROGRAM;
    assign cmd_erase = cs_rise && !busy && wel_q &&
        nbits_q == flash_status_pkg::BITS_ADDR &&
        opcode_q == flash_status_pkg::OPC_SECTOR_ERASE;
    assign cmd_whole = frame8 && !busy && wel_q && bp_q == 3'h0 &&
        opcode_q == flash_status_pkg::OPC_WHOLE_ERASE;
    assign cmd_esus = frame8 && state_q == flash_status_pkg::ST_ARRAY &&
        op_q != flash_status_pkg::OP_PROGRAM &&
        opcode_q == flash_status_pkg::OPC_ERASE_SUSPEND;
    assign cmd_psus = frame8 && state_q == flash_status_pkg::ST_ARRAY &&
        op_q == flash_status_pkg::OP_PROGRAM &&
        opcode_q == flash_status_pkg::OPC_PROGRAM_SUSPEND;

    assign array_end = state_q == flash_status_pkg::ST_ARRAY && array_rsp_in.done;
    assign array_ok = array_end && !array_rsp_in.fail;
    assign reg_end = state_q == flash_status_pkg::ST_REG &&
        wreg_cnt_q == CW'(WREG_CYCLES - 1);

    // Operation sequencer; an error parks it until clear-status
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= flash_status_pkg::ST_IDLE;
            op_q <= flash_status_pkg::OP_PROGRAM;
            wreg_cnt_q <= '0;
        end else if (cmd_rst) begin
            state_q <= flash_status_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                flash_status_pkg::ST_IDLE: begin
                    wreg_cnt_q <= '0;
                    if (cmd_wrr) begin
                        state_q <= flash_status_pkg::ST_REG;
                    end else if (cmd_prog || cmd_erase) begin
                        op_q <= cmd_prog ? flash_status_pkg::OP_PROGRAM :
                            flash_status_pkg::OP_ERASE;
                        state_q <= target_protected_in ? flash_status_pkg::ST_ERROR :
                            flash_status_pkg::ST_ARRAY;
                    end else if (cmd_whole) begin
                        op_q <= flash_status_pkg::OP_WHOLE;
                        state_q <= flash_status_pkg::ST_ARRAY;
                    end
                end
                flash_status_pkg::ST_REG: begin
                    wreg_cnt_q <= wreg_cnt_q + CW'(1);
                    if (reg_end) begin
                        state_q <= flash_status_pkg::ST_IDLE;
                    end
                end
                flash_status_pkg::ST_ARRAY: begin
                    if (cmd_esus || cmd_psus) begin
                        state_q <= flash_status_pkg::ST_IDLE;
                    end else if (array_end) begin
                        state_q <= array_rsp_in.fail ? flash_status_pkg::ST_ERROR :
                            flash_status_pkg::ST_IDLE;
                    end
                end
                flash_status_pkg::ST_ERROR: begin
                    if (cmd_clear_status_cmd) begin
                        state_q <= flash_status_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Error flags: a new error wins over a clear in the same cycle
    assign perr_set = (cmd_prog && target_protected_in) ||
        (array_end && array_rsp_in.fail && op_q == flash_status_pkg::OP_PROGRAM);
    assign eerr_set = (cmd_erase && target_protected_in) ||
        (array_end && array_rsp_in.fail && op_q != flash_status_pkg::OP_PROGRAM);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            perr_q <= 1'b0;
            eerr_q <= 1'b0;
        end else begin
            perr_q <= perr_set | (perr_q & ~cmd_clear_status_cmd & ~cmd_rst);
            eerr_q <= eerr_set | (eerr_q & ~cmd_clear_status_cmd & ~cmd_rst);
        end
    end

    // Write-enable latch; a failed operation leaves it set
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wel_q <= 1'b0;
        end else if (cmd_rst) begin
            wel_q <= 1'b0;
        end else if (cmd_write_enable_cmd) begin
            wel_q <= 1'b1;
        end else if (cmd_write_disable_cmd || reg_end || array_ok) begin
            wel_q <= 1'b0;
        end
    end

    // Lock and level bits; levels reload their volatile default
    // one cycle after reset since a reset flop cannot take a port value
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            init_q <= 1'b1;
            lock_q <= 1'b0;
            bp_q <= flash_status_pkg::BP_RESET;
        end else begin
            init_q <= 1'b0;
            if (cmd_wrr) begin
                lock_q <= wrr_byte_q[flash_status_pkg::LOCK_POS];
                bp_q <= wrr_byte_q[flash_status_pkg::BP_HI_POS:flash_status_pkg::BP_LO_POS];
            end else if ((init_q || cmd_rst) && protect_volatility_bit_in) begin
                bp_q <= flash_status_pkg::BP_VOLATILE_DEFAULT;
            end
        end
    end

    // Requests toward the array engine, one-cycle pulses
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_q <= '0;
        end else begin
            req_q.start <= ((cmd_prog || cmd_erase) && !target_protected_in) ||
                cmd_whole;
            req_q.op <= cmd_prog ? flash_status_pkg::OP_PROGRAM :
                cmd_erase ? flash_status_pkg::OP_ERASE : flash_status_pkg::OP_WHOLE;
            req_q.addr <= addr_q;
            req_q.suspend <= cmd_esus | cmd_psus;
            req_q.abort <= cmd_rst;
        end
    end

    assign array_req_out = req_q;

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_wrr_taken;
        cmd_wrr ##1 state_q == flash_status_pkg::ST_REG;
    endsequence
    sequence s_wrr_done;
        state_q == flash_status_pkg::ST_IDLE && !wel_q;
    endsequence

    property p_hw_lock;
        cs_rise && hw_lock && !busy && opcode_q == flash_status_pkg::OPC_WRITE_REGS
            |=> $stable(lock_q) && $stable(bp_q) && !busy;
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("locked write changed status");
    property p_wrr_load;
        cmd_wrr |=> lock_q == $past(wrr_byte_q[7]) && bp_q == $past(wrr_byte_q[4:2]);
    endproperty
    a_wrr_load: assert property (p_wrr_load) else $error("write did not load bits");
    property p_prog_prot;
        cmd_prog && target_protected_in |=> perr_q && busy && !req_q.start;
    endproperty
    a_prog_prot: assert property (p_prog_prot) else $error("protected program ran");
    property p_erase_prot;
        cmd_erase && target_protected_in |=> eerr_q && busy && !req_q.start;
    endproperty
    a_erase_prot: assert property (p_erase_prot) else $error("protected erase ran");
    property p_clear;
        cmd_clear_status_cmd && state_q != flash_status_pkg::ST_ARRAY |=> !perr_q && !eerr_q && !busy;
    endproperty
    a_clear: assert property (p_clear) else $error("clear-status failed");
    property p_wrr_errs;
        cmd_wrr |=> $stable(perr_q) && $stable(eerr_q);
    endproperty
    a_wrr_errs: assert property (p_wrr_errs) else $error("write altered error flags");
    property p_whole;
        frame8 && opcode_q == flash_status_pkg::OPC_WHOLE_ERASE && bp_q != 3'h0
            |=> !busy && !eerr_q && !req_q.start;
    endproperty
    a_whole: assert property (p_whole) else $error("whole erase ran protected");
    property p_wel_needed;
        cs_rise && !wel_q |=> !busy && !req_q.start;
    endproperty
    a_wel_needed: assert property (p_wel_needed) else $error("write ran without latch");
    property p_write_enable_cmd;
        cmd_write_enable_cmd |=> wel_q ##1 $stable(wel_q) || !cs_prev_q;
    endproperty
    a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("enable did not set latch");
    property p_wrr_time;
        s_wrr_taken |-> busy [*2] ##WREG_TAIL s_wrr_done;
    endproperty
    a_wrr_time: assert property (p_wrr_time) else $error("register write timing wrong");
    property p_err_busy;
        perr_q || eerr_q |-> busy || $past(cmd_rst) || $past(cmd_clear_status_cmd);
    endproperty
    a_err_busy: assert property (p_err_busy) else $error("error without busy");
    property p_busy_ignore;
        frame8 && busy && (opcode_q == flash_status_pkg::OPC_WRITE_ENABLE ||
            opcode_q == flash_status_pkg::OPC_WRITE_DISABLE)
            |=> wel_q == $past(wel_q) || $past(reg_end) || $past(array_ok);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("enable taken while busy");
    property p_rst_wel;
        cmd_rst |=> !wel_q && !busy && req_q.abort;
    endproperty
    a_rst_wel: assert property (p_rst_wel) else $error("soft reset left latch");
endmodule : flash_status_ctrl

//--- test/spi_host_model.sv
// Host side of the serial link: mode 0, clock parked low between frames
module spi_host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic mosi_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Half a link period is 4 core cycles, so the 200 ns link clock
    task automatic half();
        repeat (4) @(posedge clk_in);
        #2;
    endtask : half

    // One frame, MSB first; rx keeps the last 8 bits sampled on rising edges
    task automatic xfer(input logic [47:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        cs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi_out = tx[i];
            half();
            sck_out = 1'b1;
            rx = {rx[6:0], miso_in};
            half();
            sck_out = 1'b0;
        end
        // Released data line shows the inverse so a stale bit is never trusted
        mosi_out = ~mosi_out;
        half();
        cs_n_out = 1'b1;
        half();
        half();
    endtask : xfer
endmodule : spi_host_model

//--- test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_in = 1'b1;
    logic wp_n = 1'b1;
    logic vol = 1'b0;
    logic tprot = 1'b0;
    logic fail_mode = 1'b0;
    logic sck, cs_n, mosi, miso, miso_oe;
    flash_status_pkg::array_rsp_t rsp = '0;
    flash_status_pkg::array_req_t req;
    logic [2:0] lvl;
    logic [7:0] st, rx;
    logic [2:0] bp_r;
    logic m_lock = 1'b0, m_perr = 1'b0, m_eerr = 1'b0, m_wel = 1'b0, m_busy = 1'b0;
    logic [2:0] m_bp = 3'h0;
    int mismatches = 0;
    int check_count = 0;
    int starts = 0;
    int aborts = 0;
    logic oe_seen = 1'b0;
    logic [1:0] last_op = 2'h3;
    logic [23:0] last_addr = 24'h000000;
    int cyc = 0;

    // Core clock, 25 ns
    always #12.5 clk = ~clk;

    flash_status_ctrl #(.WREG_CYCLES(16)) flash_status_ctrl_inst (
        .ref_clk_in(clk),
        .rst_in(rst_in),
        .sck_in(sck),
        .cs_n_in(cs_n),
        .mosi_in(mosi),
        .write_protect_n_in(wp_n),
        .protect_volatility_bit_in(vol),
        .target_protected_in(tprot),
        .array_rsp_in(rsp),
        .array_req_out(req),
        .protect_level_out(lvl),
        .device_status_control_out(st),
        .miso_out(miso),
        .miso_oe_out(miso_oe)
    );

    spi_host_model spi_host_model_inst (
        .clk_in(clk),
        .miso_in(miso),
        .sck_out(sck),
        .cs_n_out(cs_n),
        .mosi_out(mosi)
    );

    // Array engine stand-in: answers every start with one done pulse
    always @(posedge clk) begin
        if (req.start === 1'b1) begin
            starts++;
            last_op = req.op;
            last_addr = req.addr;
            repeat (6) @(posedge clk);
            #2 rsp = '{done: 1'b1, fail: fail_mode};
            @(posedge clk);
            #2 rsp = '0;
        end
    end

    // Watchers for the abort pulse and the data-line drive enable
    always @(posedge clk) begin
        if (req.abort === 1'b1) begin
            aborts++;
        end
        if (miso_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic cmd(input logic [47:0] tx, input int n);
        spi_host_model_inst.xfer(tx, n, rx);
    endtask : cmd

    // Register write with lock bit and level bits in the data byte
    task automatic register_write_cmd(input logic lock, input logic [2:0] bp);
        cmd({flash_status_pkg::OPC_WRITE_REGS, lock, 2'h0, bp, 2'h0}, 16);
    endtask : register_write_cmd

    // Status read: opcode byte first, then one byte clocked back
    task automatic rdsr(input logic [7:0] opc);
        oe_seen = 1'b0;
        cmd({opc, 8'h00}, 16);
        chk("oe_seen", {7'h00, oe_seen}, 8'h01);
    endtask : rdsr

    task automatic st_chk();
        chk("status", st, {m_lock, m_perr, m_eerr, m_bp, m_wel, m_busy});
        chk("oe", {7'h00, miso_oe}, 8'h00);
    endtask : st_chk

    task automatic final_report();
        $display("mismatches=%0d check_count=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Main sequence: the model bits are updated by hand from each command's effect
    initial begin
        void'($urandom(33));
        tick(10);
        rst_in = 1'b0;
        tick(4);
        st_chk();
        register_write_cmd(1'b1, 3'h7);
        tick(20);
        st_chk();
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        m_wel = 1'b1;
        st_chk();
        rdsr(flash_status_pkg::OPC_READ_STATUS);
        chk("read", rx, {m_lock, m_perr, m_eerr, m_bp, m_wel, m_busy});
        rdsr(flash_status_pkg::OPC_READ_STATUS2);
        chk("read2", rx, flash_status_pkg::STATUS2_VALUE);
        bp_r = 3'($urandom);
        register_write_cmd(1'b1, bp_r);
        {m_lock, m_bp, m_busy} = {1'b1, bp_r, 1'b1};
        st_chk();
        chk("level", {5'h00, lvl}, {5'h00, bp_r});
        tick(20);
        {m_busy, m_wel} = 2'b00;
        st_chk();
        // Lock set and pin low: write refused, latch untouched
        wp_n = 1'b0;
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        m_wel = 1'b1;
        register_write_cmd(1'b0, 3'h1);
        tick(20);
        st_chk();
        wp_n = 1'b1;
        register_write_cmd(1'b0, 3'h1);
        {m_lock, m_bp} = {1'b0, 3'h1};
        tick(20);
        m_wel = 1'b0;
        st_chk();
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        cmd(flash_status_pkg::OPC_WHOLE_ERASE, 8);
        tick(12);
        m_wel = 1'b1;
        st_chk();
        chk("starts", 8'(starts), 8'h00);
        register_write_cmd(1'b0, 3'h0);
        tick(20);
        {m_bp, m_wel} = 4'h0;
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        cmd(flash_status_pkg::OPC_WHOLE_ERASE, 8);
        tick(12);
        st_chk();
        chk("starts", 8'(starts), 8'h01);
        chk("op", {6'h00, last_op}, 8'h02);
        // Failing program: error holds busy until clear-status
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        fail_mode = 1'b1;
        cmd({flash_status_pkg::OPC_PROGRAM, 24'h012345, 8'ha5}, 40);
        tick(12);
        {m_perr, m_busy, m_wel} = 3'b111;
        st_chk();
        chk("op", {6'h00, last_op}, 8'h00);
        chk("addr", last_addr[15:8], 8'h23);
        cmd(flash_status_pkg::OPC_WRITE_DISABLE, 8);
        st_chk();
        rdsr(flash_status_pkg::OPC_READ_STATUS);
        chk("read", rx, {m_lock, m_perr, m_eerr, m_bp, m_wel, m_busy});
        cmd(flash_status_pkg::OPC_CLEAR_STATUS, 8);
        {m_perr, m_busy} = 2'b00;
        st_chk();
        cmd(flash_status_pkg::OPC_WRITE_DISABLE, 8);
        m_wel = 1'b0;
        st_chk();
        // Program into a protected area: flag set, nothing started
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        tprot = 1'b1;
        cmd({flash_status_pkg::OPC_PROGRAM, 24'h040000, 8'h5a}, 40);
        tprot = 1'b0;
        {m_perr, m_busy, m_wel} = 3'b111;
        st_chk();
        cmd(flash_status_pkg::OPC_CLEAR_STATUS, 8);
        cmd(flash_status_pkg::OPC_WRITE_DISABLE, 8);
        {m_perr, m_busy, m_wel} = 3'b000;
        st_chk();
        // Erase of a protected sector: flag set, nothing started
        cmd(flash_status_pkg::OPC_WRITE_ENABLE, 8);
        tprot = 1'b1;
        cmd({flash_status_pkg::OPC_SECTOR_ERASE, 24'h040000}, 32);
        tprot = 1'b0;
        {m_eerr, m_busy, m_wel} = 3'b111;
        st_chk();
        chk("starts", 8'(starts), 8'h02);
        cmd(flash_status_pkg::OPC_CLEAR_STATUS, 8);
        cmd(flash_status_pkg::OPC_WRITE_DISABLE, 8);
        {m_eerr, m_busy, m_wel} = 3'b000;
        st_chk();
        // Volatile levels come back as ones after soft and hard reset
        vol = 1'b1;
        cmd(flash_status_pkg::OPC_SOFT_RESET, 8);
        m_bp = 3'h7;
        st_chk();
        chk("aborts", 8'(aborts), 8'h01);
        rst_in = 1'b1;
        tick(3);
        rst_in = 1'b0;
        tick(4);
        st_chk();
        final_report();
    end
endmodule : tb_top
